// File: common/jif_regs.svh
// register indices, bit masks, reset values and timing counts
`ifndef JIF_REGS_SVH
`define JIF_REGS_SVH
`define JIF_IDX_ERR 8'h22
`define JIF_IDX_XFER 8'h23
`define JIF_IDX_LINE 8'h24
`define JIF_IDX_RDONE 8'h21
`define JIF_IDX_CTRL 8'h30
`define JIF_FLAG_RST 8'h00
`define JIF_CTRL_RST 4'h0
`define JIF_XFER_MASK 8'hEF
`define JIF_LINE_MASK 8'hBF
`define JIF_LINE_MASK_LITE 8'h3F
`define JIF_MAX_FRAME 12
`define JIF_CLK_NS 5
`define JIF_DOM_STUCK_NS 48000
`define JIF_SLOW_SCALE 4
`endif

// File: common/jif_pkg.sv
// types shared by the flag block
package jif_pkg;
   // one-cycle event strobes from receiver, transmitter, monitor
   typedef struct packed {
      logic rx_sof;
      logic rx_byte;
      logic rx_msg_ok;
      logic rx_reply_ok;
      logic rx_break;
      logic rx_crc_bad;
      logic rx_framing_fault_bad;
      logic rx_bad_symbol;
      logic rx_ifs_talk;
      logic tx_start;
      logic tx_lost;
      logic tx_no_reply;
      logic tx_done;
      logic tx_ifr_req;
      logic tx_ifr_ok;
      logic ifr3_request;
      logic reply_armed;
      logic link_check;
      logic [5:0] line;
   } jif_evt_t;
   // control register fields
   typedef struct packed {
      logic slow_rate;
      logic [2:0] retries;
   } jif_ctrl_t;
endpackage

// File: rtl/jif_flags.sv
// interrupt request flag registers behind an ahb-lite slave
`timescale 1ns/10ps
`default_nettype none
`include "jif_regs.svh"
module jif_flags
   import jif_pkg::*;
#(
   parameter int DOM_CYC = `JIF_DOM_STUCK_NS / `JIF_CLK_NS,
   parameter bit HAS_LINK_CHECK = 1'b1
)(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // ahb-lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // events
   input wire jif_evt_t evt_in,
   // bus line drive and sense, high = dominant
   input wire logic [1:0] bus_drive_output_in,
   input wire logic [1:0] bus_sense_input_in
);
   logic [7:0] err_flags;
   logic [7:0] xfer_flags;
   logic [7:0] line_flags;
   logic [7:0] next_err_set;
   logic [7:0] next_xfer_set;
   logic [7:0] next_line_set;
   jif_ctrl_t ctrl;
   logic wr_pend;
   logic [7:0] wr_idx;
   logic [7:0] wr_clear_err;
   logic [7:0] wr_clear_xfer;
   logic [7:0] wr_clear_line;
   logic rd_pending;
   logic [3:0] frame_bytes;
   logic [15:0] dom_cnt;
   logic [15:0] dom_limit;
   logic [2:0] fail_cnt;
   logic [7:0] line_mask;
   logic addr_ok;
   logic [7:0] a_idx;

   // address phase decode
   assign addr_ok = hsel_in && hready_in && htrans_in[1];
   assign a_idx = haddr_in[9:2];
   assign line_mask = HAS_LINK_CHECK ? `JIF_LINE_MASK
                                     : `JIF_LINE_MASK_LITE;
   assign dom_limit = ctrl.slow_rate
      ? 16'(DOM_CYC * `JIF_SLOW_SCALE) : 16'(DOM_CYC);

   // write phase clear masks, all ones when no write hits
   always_comb
   begin
      wr_clear_err = 8'hFF;
      wr_clear_xfer = 8'hFF;
      wr_clear_line = 8'hFF;
      if (wr_pend && wr_idx == `JIF_IDX_ERR)
         wr_clear_err = hwdata_in[7:0];
      if (wr_pend && wr_idx == `JIF_IDX_XFER)
         wr_clear_xfer = hwdata_in[7:0];
      if (wr_pend && wr_idx == `JIF_IDX_LINE)
         wr_clear_line = hwdata_in[7:0];
   end

   // bus fixed answer: no wait, always okay
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         hreadyout_out <= 1'b0;
         hresp_out <= 1'b0;
      end
      else
      begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   // capture write address phase
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         wr_pend <= 1'b0;
         wr_idx <= 8'h00;
      end
      else
      begin
         wr_pend <= addr_ok && hwrite_in;
         wr_idx <= a_idx;
      end
   end

   // read data, registered in the address phase
   // a read right after a write returns the old value
   // unused bits zero
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         hrdata_out <= 32'h0000_0000;
      else if (addr_ok && !hwrite_in)
      begin
         unique case (a_idx)
            `JIF_IDX_ERR: hrdata_out <= {24'h00_0000, err_flags};
            `JIF_IDX_XFER: hrdata_out <= {24'h00_0000, xfer_flags};
            `JIF_IDX_LINE: hrdata_out <= {24'h00_0000, line_flags};
            `JIF_IDX_CTRL: hrdata_out <= {28'h000_0000, ctrl};
            default: hrdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // control register: rate and retry count
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         ctrl <= jif_ctrl_t'(`JIF_CTRL_RST);
      else if (wr_pend && wr_idx == `JIF_IDX_CTRL)
         ctrl <= jif_ctrl_t'(hwdata_in[3:0]);
   end

   // received message waiting for host read-done
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         rd_pending <= 1'b0;
      else if (evt_in.rx_msg_ok)
         rd_pending <= 1'b1;
      else if (wr_pend && wr_idx == `JIF_IDX_RDONE)
         rd_pending <= 1'b0;
   end

   // byte count of the frame being received
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         frame_bytes <= 4'h0;
      else if (evt_in.rx_sof)
         frame_bytes <= 4'h0;
      else if (evt_in.rx_byte && frame_bytes != 4'hF)
         frame_bytes <= frame_bytes + 4'h1;
   end

   // dominant time counter, scaled by bit rate
   // saturates past the limit so the flag fires once
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         dom_cnt <= 16'h0000;
      else if (bus_sense_input_in == 2'b00)
         dom_cnt <= 16'h0000;
      else if (dom_cnt <= dom_limit)
         dom_cnt <= dom_cnt + 16'h0001;
   end

   // failed attempts of the current transmission
   // only failed attempts counted, holding at seven
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         fail_cnt <= 3'h0;
      else if (evt_in.tx_start)
         fail_cnt <= 3'h0;
      else if ((evt_in.tx_lost || evt_in.tx_no_reply)
               && fail_cnt != 3'h7)
         fail_cnt <= fail_cnt + 3'h1;
   end

   // set terms for the error register
   always_comb
   begin
      next_err_set = 8'h00;
      next_err_set[7] = evt_in.rx_byte
         && frame_bytes == 4'(`JIF_MAX_FRAME);
      next_err_set[6] = bus_sense_input_in != 2'b00
         && dom_cnt == dom_limit;
      next_err_set[5] = bus_drive_output_in == 2'b11
         && bus_sense_input_in == 2'b00;
      next_err_set[4] = evt_in.rx_msg_ok && rd_pending;
      next_err_set[3] = evt_in.rx_crc_bad;
      next_err_set[2] = evt_in.rx_framing_fault_bad;
      next_err_set[1] = evt_in.rx_bad_symbol;
      next_err_set[0] = evt_in.rx_ifs_talk;
   end

   // set terms for the transfer register
   always_comb
   begin
      next_xfer_set = 8'h00;
      next_xfer_set[7] = evt_in.tx_lost && fail_cnt == ctrl.retries;
      next_xfer_set[6] = evt_in.tx_no_reply
         && fail_cnt == ctrl.retries;
      next_xfer_set[5] = evt_in.ifr3_request && !evt_in.reply_armed;
      next_xfer_set[3] = evt_in.rx_break;
      next_xfer_set[2] = evt_in.rx_reply_ok;
      next_xfer_set[1] = evt_in.rx_msg_ok;
      next_xfer_set[0] = evt_in.tx_done
         && (!evt_in.tx_ifr_req || evt_in.tx_ifr_ok);
   end

   // set terms for the line register
   always_comb
   begin
      next_line_set = {evt_in.link_check, 1'b0, evt_in.line};
   end

   // flag registers: set wins, zero write clears
   // sticky flags
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         err_flags <= `JIF_FLAG_RST;
         xfer_flags <= `JIF_FLAG_RST;
         line_flags <= `JIF_FLAG_RST;
      end
      else
      begin
         err_flags <= (err_flags & wr_clear_err) | next_err_set;
         xfer_flags <= ((xfer_flags & wr_clear_xfer)
                        | next_xfer_set) & `JIF_XFER_MASK;
         line_flags <= ((line_flags & wr_clear_line)
                        | next_line_set) & line_mask;
      end
   end

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   a_flag_sticky: assert property (
      err_flags[3] && !(wr_pend && wr_idx == `JIF_IDX_ERR)
      |=> err_flags[3])
      else $error("crc flag dropped without a clear");

   a_zero_clears: assert property (
      wr_pend && wr_idx == `JIF_IDX_XFER && !hwdata_in[0]
      && !next_xfer_set[0] |=> !xfer_flags[0])
      else $error("zero write did not clear send_complete");

   a_one_keeps: assert property (
      wr_pend && wr_idx == `JIF_IDX_XFER && hwdata_in[5]
      && xfer_flags[5] |=> xfer_flags[5])
      else $error("one write disturbed missing_reply_data");

   a_reset_clear: assert property (
      $past(rst_in) |-> err_flags == 8'h00
      && xfer_flags == 8'h00 && line_flags == 8'h00)
      else $error("flags not zero after reset");

   a_reserved_zero: assert property (
      !xfer_flags[4] && !line_flags[6])
      else $error("reserved flag bit set");

   a_len_flag: assert property (
      evt_in.rx_byte && frame_bytes == 4'd12 && !evt_in.rx_sof
      |=> err_flags[7])
      else $error("thirteenth byte did not set frame_too_long");

   a_dom_stuck: assert property (
      $rose(err_flags[6]) |-> $past(bus_sense_input_in) != 2'b00)
      else $error("dominant_stuck set while bus passive");

   a_drive_fault: assert property (
      bus_sense_input_in != 2'b00 && !err_flags[5]
      ##0 !(wr_pend && wr_idx == `JIF_IDX_ERR) |=> !err_flags[5])
      else $error("drive fault with a sensing line");

   a_overrun: assert property (
      evt_in.rx_msg_ok ##1 evt_in.rx_msg_ok
      && !(wr_pend && wr_idx == `JIF_IDX_RDONE) |=> err_flags[4])
      else $error("back to back messages gave no overrun");

   a_tr_suppress: assert property (
      $rose(xfer_flags[0]) |-> $past(!evt_in.tx_ifr_req
      || evt_in.tx_ifr_ok))
      else $error("send_complete after failed reply");

   a_set_wins: assert property (
      next_err_set[3] && wr_pend && wr_idx == `JIF_IDX_ERR
      |=> err_flags[3])
      else $error("clear beat a same cycle set");

   a_bus_ready: assert property (
      !$past(rst_in) |-> hreadyout_out && !hresp_out)
      else $error("slave not ready or error response");

   // each event source checked below lands in its own flag bit; line is checked on bit 0 only
   a_drive_both: assert property (
      bus_drive_output_in == 2'b11 && bus_sense_input_in == 2'b00
      |=> err_flags[5])
      else $error("both lines passive gave no drive fault");

   a_crc_set: assert property (
      evt_in.rx_crc_bad |=> err_flags[3])
      else $error("crc failure did not set its flag");

   a_framing_fault_set: assert property (
      evt_in.rx_framing_fault_bad |=> err_flags[2])
      else $error("misplaced symbol did not set framing_fault");

   a_symbol_set: assert property (
      evt_in.rx_bad_symbol |=> err_flags[1])
      else $error("bad encoding did not set bad_bit_symbol");

   a_ifs_set: assert property (
      evt_in.rx_ifs_talk |=> err_flags[0])
      else $error("ifs intrusion did not set its flag");

   a_lost_cause: assert property (
      $rose(xfer_flags[7]) |-> $past(evt_in.tx_lost))
      else $error("arbitration flag without a lost attempt");

   a_noreply_cause: assert property (
      $rose(xfer_flags[6]) |-> $past(evt_in.tx_no_reply))
      else $error("no_reply_after_retries without a failed try");

   a_reply_missing: assert property (
      evt_in.ifr3_request && !evt_in.reply_armed |=> xfer_flags[5])
      else $error("unarmed request did not set missing_reply_data");

   a_recv_set: assert property (
      evt_in.rx_msg_ok |=> xfer_flags[1])
      else $error("valid message did not set message_received");

   a_done_set: assert property (
      evt_in.tx_done && !evt_in.tx_ifr_req |=> xfer_flags[0])
      else $error("normal transmit end did not set send_complete");

   a_line_set: assert property (
      evt_in.line[0] |=> line_flags[0])
      else $error("line event did not set its flag");

   c_overrun: cover property (err_flags[4] && xfer_flags[1]);
   c_retry_lost: cover property (
      evt_in.tx_lost ##[1:20] xfer_flags[7]);
   c_set_clear: cover property (
      next_xfer_set[0] && wr_pend && wr_idx == `JIF_IDX_XFER);
   c_stuck: cover property ($rose(err_flags[6]));
   c_too_long: cover property ($rose(err_flags[7]));

endmodule // jif_flags
`default_nettype wire

// File: test/jif_host.sv
// host cpu model: ahb-lite master that reads and clears flags
`timescale 1ns/10ps
`default_nettype none
module jif_host (
   // clock
   input wire logic mclk_in,
   // bus requests
   output logic hsel_out,
   output logic [31:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [2:0] hsize_out,
   output logic [31:0] hwdata_out,
   // slave answer
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in
);
   // idle bus from time zero
   initial
   begin
      hsel_out = 1'b0;
      haddr_out = 32'h0000_0000;
      htrans_out = 2'h0;
      hwrite_out = 1'b0;
      hsize_out = 3'h2;
      hwdata_out = 32'h0000_0000;
   end
   // one single word transfer, held until hready
   task automatic xfer(input logic wr, input logic [7:0] idx,
      input logic [31:0] d, output logic [31:0] q);
      hsel_out <= 1'b1;
      haddr_out <= {22'h00_0000, idx, 2'b00};
      htrans_out <= 2'h2;
      hwrite_out <= wr;
      do @(posedge mclk_in); while (hready_in !== 1'b1);
      hsel_out <= 1'b0;
      htrans_out <= 2'h0;
      hwdata_out <= d;
      do @(posedge mclk_in); while (hready_in !== 1'b1);
      q = hrdata_in;
      hwdata_out <= ~d; // released data no longer valid
   endtask
endmodule // jif_host
`default_nettype wire

// File: test/jif_flags_tb.sv
// bench for the flag registers over ahb-lite
`timescale 1ns/10ps
`default_nettype none
`include "jif_regs.svh"
module jif_flags_tb
   import jif_pkg::*;
;
   localparam int DOM = 20;
   localparam logic [7:0] ERR = `JIF_IDX_ERR;
   localparam logic [7:0] XFR = `JIF_IDX_XFER;
   localparam logic [7:0] LIN = `JIF_IDX_LINE;
   logic mclk_in, rst_in, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [31:0] hrdata_lite;
   logic hready_lite, hresp_lite;
   logic [1:0] htrans, drv, sns;
   logic [2:0] hsize;
   jif_evt_t evt;
   int failures, n_checks;
   // 200 MHz clock
   initial
   begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end
   jif_host i_host (.mclk_in(mclk_in), .hsel_out(hsel), .haddr_out(haddr),
      .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
      .hwdata_out(hwdata), .hready_in(hready), .hrdata_in(hrdata));
   jif_flags #(.DOM_CYC(DOM)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready),
      .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .evt_in(evt), .bus_drive_output_in(drv),
      .bus_sense_input_in(sns));
   // reduced variant without the link check bit
   jif_flags #(.DOM_CYC(DOM), .HAS_LINK_CHECK(1'b0)) i_dut_lite (
      .mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata),
      .hrdata_out(hrdata_lite), .hreadyout_out(hready_lite),
      .hresp_out(hresp_lite), .evt_in(evt), .bus_drive_output_in(drv),
      .bus_sense_input_in(sns));
   // read one register and compare
   task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] r;
      i_host.xfer(1'b0, idx, 32'h0000_0000, r);
      n_checks++;
      if (r !== {24'h00_0000, exp} || hresp !== 1'b0)
      begin
         failures++;
         $display("wrong value at %0t: idx %h got %h", $time, idx, r);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      i_host.xfer(1'b1, idx, {24'h00_0000, d}, r);
   endtask
   // one-cycle event strobe, then settle
   task automatic strobe;
      @(posedge mclk_in);
      evt <= '0;
      repeat (2) @(posedge mclk_in);
   endtask
   task automatic results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog against a hung bus
   initial
   begin
      repeat (20000) @(posedge mclk_in);
      failures++;
      results();
   end
   // main sequence
   initial
   begin
      rst_in = 1'b1;
      evt = '0;
      drv = 2'b00;
      sns = 2'b00;
      failures = 0;
      n_checks = 0;
      repeat (20) @(posedge mclk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      chk(ERR, 8'h00);
      chk(XFR, 8'h00);
      chk(LIN, 8'h00);
      chk(8'h3F, 8'h00);
      evt.rx_crc_bad <= 1'b1;
      strobe();
      chk(ERR, 8'h08);
      evt.rx_framing_fault_bad <= 1'b1;
      strobe();
      chk(ERR, 8'h0C);
      evt.rx_bad_symbol <= 1'b1;
      strobe();
      chk(ERR, 8'h0E);
      evt.rx_ifs_talk <= 1'b1;
      strobe();
      chk(ERR, 8'h0F);
      wr(ERR, 8'hFB);
      chk(ERR, 8'h0B);
      // crc set lands on the clearing edge
      fork
         wr(ERR, 8'h00);
         begin
            @(posedge mclk_in);
            evt.rx_crc_bad <= 1'b1;
            @(posedge mclk_in);
            evt <= '0;
         end
      join
      chk(ERR, 8'h08);
      wr(ERR, 8'h00);
      evt.rx_msg_ok <= 1'b1;
      strobe();
      chk(XFR, 8'h02);
      wr(`JIF_IDX_RDONE, 8'h00);
      evt.rx_msg_ok <= 1'b1;
      strobe();
      chk(ERR, 8'h00);
      evt.rx_msg_ok <= 1'b1;
      strobe();
      chk(ERR, 8'h10);
      // back to back messages after read-done
      wr(ERR, 8'h00);
      wr(`JIF_IDX_RDONE, 8'h00);
      evt.rx_msg_ok <= 1'b1;
      @(posedge mclk_in);
      strobe();
      chk(ERR, 8'h10);
      evt.rx_break <= 1'b1;
      strobe();
      chk(XFR, 8'h0A);
      evt.rx_reply_ok <= 1'b1;
      strobe();
      chk(XFR, 8'h0E);
      evt.tx_done <= 1'b1;
      strobe();
      chk(XFR, 8'h0F);
      wr(XFR, 8'h00);
      evt.tx_done <= 1'b1;
      evt.tx_ifr_req <= 1'b1;
      strobe();
      chk(XFR, 8'h00);
      evt.ifr3_request <= 1'b1;
      evt.reply_armed <= 1'b1;
      strobe();
      chk(XFR, 8'h00);
      evt.ifr3_request <= 1'b1;
      strobe();
      chk(XFR, 8'h20);
      wr(XFR, 8'hFF);
      chk(XFR, 8'h20);
      wr(XFR, 8'h00);
      // flag only on last of three tries
      wr(`JIF_IDX_CTRL, 8'h02);
      for (int m = 0; m < 2; m++)
      begin
         evt.tx_start <= 1'b1;
         strobe();
         for (int k = 0; k < 3; k++)
         begin
            evt.tx_lost <= (m == 0);
            evt.tx_no_reply <= (m == 1);
            strobe();
            chk(XFR, (k == 2) ? (8'h80 >> m) : 8'h00);
         end
         wr(XFR, 8'h00);
      end
      evt.rx_sof <= 1'b1;
      strobe();
      for (int k = 1; k < 14; k++)
      begin
         evt.rx_byte <= 1'b1;
         strobe();
         if (k > 11)
            chk(ERR, (k == 13) ? 8'h90 : 8'h10);
      end
      drv <= 2'b11;
      sns <= 2'b01;
      repeat (5) @(posedge mclk_in);
      chk(ERR, 8'h90);
      sns <= 2'b00;
      repeat (2) @(posedge mclk_in);
      drv <= 2'b00;
      chk(ERR, 8'hB0);
      wr(ERR, 8'h00);
      for (int r = 0; r < 2; r++)
      begin
         wr(`JIF_IDX_CTRL, r ? 8'h08 : 8'h00);
         sns <= 2'b10;
         repeat (DOM * (r ? 4 : 1) - 5) @(posedge mclk_in);
         sns <= 2'b00;
         chk(ERR, 8'h00);
         sns <= 2'b10;
         repeat (DOM * (r ? 4 : 1) + 5) @(posedge mclk_in);
         sns <= 2'b00;
         chk(ERR, 8'h40);
         wr(ERR, 8'h00);
      end
      // line bits with reserved bit six
      evt.line <= 6'h3F;
      evt.link_check <= 1'b1;
      strobe();
      chk(LIN, 8'hBF);
      // reduced variant read the same word without bit seven
      n_checks++;
      if (hrdata_lite !== 32'h0000_003F || hready_lite !== 1'b1 || hresp_lite !== 1'b0)
      begin
         failures++;
         $display("wrong value at %0t: reduced line %h", $time, hrdata_lite);
      end
      wr(LIN, 8'h7F);
      chk(LIN, 8'h3F);
      results();
   end
endmodule // jif_flags_tb
`default_nettype wire
